// *** flcsm_core.sv ***
`timescale 1ns/1ps
// lock-table command interpreter with per-bank output modes, APB slave
module flcsm_core #(
    parameter int BANKS = 8,
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output flcsm_pkg::flcsm_state_type cur_state,
    output flcsm_pkg::flcsm_out_type read_mode,
    output logic seq_fail,
    output logic fact_active
);
    import flcsm_pkg::*;

    // ==========================================
    // bus side
    logic access;
    logic wr_cmd;
    logic wr_ctrl;
    logic done_evt;
    flcsm_cmd_type cmd;
    logic [7:0] code;
    logic is_setup;
    logic is_lockcfm;
    logic is_cfgcfm;
    logic is_status_sel;
    logic is_illegal;

    assign access = psel && penable && clk_en;
    assign wr_cmd = access && pwrite && (paddr == ADDR_CMD);
    assign wr_ctrl = access && pwrite && (paddr == ADDR_CTRL);
    assign done_evt = wr_ctrl && pwdata[CTRL_DONE_BIT];
    assign cmd = pwdata[26:0];
    assign code = cmd.data[7:0];

    flcsm_decode u_decode (
        .code(code),
        .is_setup(is_setup),
        .is_lockcfm(is_lockcfm),
        .is_cfgcfm(is_cfgcfm),
        .is_status_sel(is_status_sel),
        .is_illegal(is_illegal)
    );

    // ==========================================
    // state
    flcsm_state_type state;
    flcsm_state_type next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [7:0] first_block;
    logic [7:0] next_first_block;
    logic fail;
    logic next_fail;
    logic sr0;
    logic next_sr0;
    logic [2:0] rbank;
    logic [2:0] next_rbank;
    flcsm_out_type bank_mode [BANKS];
    flcsm_out_type next_bank_mode [BANKS];
    flcsm_out_type sel_mode;
    logic sel_valid;

    always_comb begin
        next_state = state;
        next_count = count;
        next_first_block = first_block;
        next_fail = fail;
        next_sr0 = sr0;
        next_rbank = rbank;
        if (wr_ctrl) begin
            next_sr0 = pwdata[CTRL_SR0_BIT];
            next_rbank = pwdata[CTRL_RBANK_LSB +: 3];
        end
        if (done_evt) begin
            case (state)
                ST_OTP_BUSY, ST_PROG_BUSY, ST_ERASE_BUSY: next_state = ST_READY;
                ST_BLANK_BUSY, ST_ILL_BLANK: next_state = ST_READY;
                ST_ILL_BUSY: next_state = ST_ILL_READY;
                ST_BP_BUSY_ES: next_state = ST_ERASE_SUSP;
                ST_ILL_BP_BUSY_ES: next_state = ST_ILL_SUSP;
                default: next_state = state;
            endcase
        end else if (wr_cmd) begin
            case (state)
                ST_READY, ST_ILL_READY, ST_ERROR_READY: begin
                    if (code == CODE_LOCK_SETUP) begin
                        next_state = ST_LOCK_SETUP;
                    end else if (code == CODE_OTP_SETUP) begin
                        next_state = ST_OTP_SETUP;
                    end else if (code == CODE_FACT_SETUP && !sr0) begin
                        next_state = ST_FACT_SETUP;
                    end else if (code == CODE_PROG_SETUP || code == CODE_PROG_SETUP_ALT) begin
                        next_state = ST_PROG_SETUP;
                    end else if (code == CODE_ERASE_SETUP) begin
                        next_state = ST_ERASE_SETUP;
                    end else if (code == CODE_BLANK_SETUP) begin
                        next_state = ST_BLANK_SETUP;
                    end
                end
                ST_LOCK_SETUP: next_state = (is_lockcfm || is_cfgcfm) ? ST_READY : ST_ERROR_READY;
                ST_OTP_SETUP: next_state = ST_OTP_BUSY;
                // only the entries needed to reach the busy and suspend states
                ST_PROG_SETUP: next_state = ST_PROG_BUSY;
                ST_ERASE_SETUP: next_state = (code == CODE_CONFIRM) ? ST_ERASE_BUSY : ST_ERROR_READY;
                ST_BLANK_SETUP: next_state = (code == CODE_BLANK_CONFIRM) ? ST_BLANK_BUSY : ST_ERROR_READY;
                ST_OTP_BUSY, ST_PROG_BUSY, ST_ERASE_BUSY: begin
                    if (is_setup) begin
                        next_state = ST_ILL_BUSY;
                    end else if (code == CODE_SUSPEND && state != ST_OTP_BUSY) begin
                        next_state = (state == ST_PROG_BUSY) ? ST_PROG_SUSP : ST_ERASE_SUSP;
                    end
                end
                ST_BLANK_BUSY: if (is_setup) next_state = ST_ILL_BLANK;
                ST_ERASE_SUSP: begin
                    if (code == CODE_LOCK_SETUP) begin
                        next_state = ST_LOCK_SETUP_ES;
                    end else if (is_setup) begin
                        next_state = ST_ILL_SUSP;
                    end else if (code == CODE_BUF_PROG) begin
                        next_state = ST_BP_SETUP_ES;
                    end
                end
                ST_PROG_SUSP, ST_BP_SUSP_ES: if (is_setup) next_state = ST_ILL_SUSP;
                ST_BP_SETUP_ES: begin
                    next_count = cmd.data[CNT_W-1:0];
                    next_first_block = cmd.block;
                    next_fail = 1'b0;
                    next_state = ST_BP_LOAD1_ES;
                end
                ST_BP_LOAD1_ES: begin
                    if (cmd.block != first_block) next_fail = 1'b1;
                    next_state = (count == '0) ? ST_BP_CONFIRM_ES : ST_BP_LOAD2_ES;
                end
                ST_BP_LOAD2_ES: begin
                    if (cmd.block != first_block) next_fail = 1'b1;
                    next_count = count - 1'b1;
                    if (count == CNT_W'(1)) next_state = ST_BP_CONFIRM_ES;
                end
                ST_BP_CONFIRM_ES: next_state = (code == CODE_CONFIRM && !fail) ? ST_BP_BUSY_ES : ST_ERASE_SUSP;
                ST_BP_BUSY_ES: if (is_setup) next_state = ST_ILL_BP_BUSY_ES;
                ST_LOCK_SETUP_ES: next_state = ST_ERASE_SUSP;
                ST_FACT_SETUP: begin
                    next_first_block = cmd.block;
                    next_state = (code == CODE_CONFIRM) ? ST_FACT_BUSY : ST_ERROR_READY;
                end
                ST_FACT_BUSY: begin
                    if (cmd.block != first_block && cmd.data == FACT_EXIT_DATA) next_state = ST_READY;
                end
                default: next_state = state;
            endcase
        end
    end

    // ==========================================
    // per-bank output mode
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        always_comb begin
            next_bank_mode[b] = bank_mode[b];
            if (wr_cmd && !done_evt && cmd.bank == 3'(b)) begin
                case (state)
                    ST_LOCK_SETUP_ES: next_bank_mode[b] = is_cfgcfm ? OUT_ARRAY : OUT_STATUS;
                    ST_PROG_SETUP, ST_ERASE_SETUP, ST_BLANK_SETUP,
                    ST_LOCK_SETUP, ST_OTP_SETUP, ST_BP_SETUP_ES, ST_BP_LOAD1_ES, ST_BP_LOAD2_ES,
                    ST_BP_CONFIRM_ES, ST_FACT_SETUP, ST_FACT_BUSY: next_bank_mode[b] = OUT_STATUS;
                    ST_ILL_BUSY, ST_ILL_READY, ST_ILL_BLANK, ST_ILL_SUSP, ST_ILL_BP_BUSY_ES:
                        next_bank_mode[b] = bank_mode[b];
                    default: begin
                        if (is_illegal) begin
                            next_bank_mode[b] = bank_mode[b];
                        end else if (is_status_sel || code == CODE_READ_STATUS) begin
                            next_bank_mode[b] = OUT_STATUS;
                        end else if (is_cfgcfm || code == CODE_READ_ARRAY) begin
                            next_bank_mode[b] = OUT_ARRAY;
                        end else if (code == CODE_READ_SIG) begin
                            next_bank_mode[b] = OUT_SIG;
                        end else if (code == CODE_READ_CFI) begin
                            next_bank_mode[b] = OUT_CFI;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                bank_mode[b] <= OUT_ARRAY;
            end else if (clk_en) begin
                bank_mode[b] <= next_bank_mode[b];
            end
        end
    end

    // read only sees a mode when the read bank matches the last command bank
    logic [2:0] last_bank;
    logic [2:0] next_last_bank;
    assign next_last_bank = wr_cmd ? cmd.bank : last_bank;
    assign sel_valid = (rbank == last_bank);
    assign sel_mode = sel_valid ? bank_mode[rbank] : OUT_ARRAY;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_READY;
            count <= '0;
            first_block <= '0;
            fail <= 1'b0;
            sr0 <= RESET_CTRL[0];
            rbank <= '0;
            last_bank <= '0;
        end else if (clk_en) begin
            state <= next_state;
            count <= next_count;
            first_block <= next_first_block;
            fail <= next_fail;
            sr0 <= next_sr0;
            rbank <= next_rbank;
            last_bank <= next_last_bank;
        end
    end

    // ==========================================
    // outputs and read data
    logic [31:0] next_prdata;
    logic next_pslverr;

    always_comb begin
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && !penable && !pwrite) begin
            if (paddr == ADDR_CMD) begin
                next_prdata = '0;
            end else if (paddr == ADDR_STATE) begin
                next_prdata = {26'h000_0000, fail, state};
            end else if (paddr == ADDR_MODE) begin
                next_prdata = {29'h0000_0000, sel_valid, sel_mode};
            end else if (paddr == ADDR_CTRL) begin
                next_prdata = {25'h000_0000, rbank, 2'h0, sr0, 1'b0};
            end else begin
                next_prdata = '0;
            end
        end
        if (psel && !penable) begin
            next_pslverr = !(paddr == ADDR_CMD || paddr == ADDR_STATE || paddr == ADDR_MODE || paddr == ADDR_CTRL);
        end else if (psel) begin
            next_pslverr = pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            cur_state <= ST_READY;
            read_mode <= OUT_ARRAY;
            seq_fail <= 1'b0;
            fact_active <= 1'b0;
        end else if (clk_en) begin
            prdata <= next_prdata;
            pready <= psel && !penable;
            pslverr <= next_pslverr;
            cur_state <= next_state;
            read_mode <= sel_mode;
            seq_fail <= next_fail;
            fact_active <= (next_state == ST_FACT_BUSY);
        end
    end
endmodule : flcsm_core

// *** flcsm_core_asserts.sv ***
`timescale 1ns/1ps
// ==========================================
// port-level checks of the lock-table interpreter
module flcsm_core_asserts #(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire flcsm_pkg::flcsm_state_type cur_state,
    input wire flcsm_pkg::flcsm_out_type read_mode,
    input wire logic seq_fail,
    input wire logic fact_active
);
    import flcsm_pkg::*;
    logic wr_ok;
    logic cmd_wr;
    logic setup_code;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    assign wr_ok = psel && penable && pwrite && pready && clk_en;
    assign cmd_wr = wr_ok && paddr == ADDR_CMD;
    assign setup_code = pwdata[7:0] == CODE_LOCK_SETUP || pwdata[7:0] == CODE_OTP_SETUP;
    // ==========================================
    // remaining words, so the load branches can be judged exactly
    always_comb begin
        next_cnt = cnt;
        if (cmd_wr && cur_state == ST_BP_SETUP_ES) begin
            next_cnt = pwdata[CNT_W-1:0];
        end else if (cmd_wr && cur_state == ST_BP_LOAD2_ES) begin
            next_cnt = cnt - CNT_W'(1);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
    // ==========================================
    // assertions
    chk_ready_answer: assert property (psel && !penable && clk_en |=> pready && !$stable(pready))
        else $error("no ready in access cycle");
    chk_busy_shadow: assert property (cmd_wr && setup_code &&
        cur_state inside {ST_PROG_BUSY, ST_ERASE_BUSY} |=> cur_state == ST_ILL_BUSY)
        else $error("setup in busy not shadowed");
    chk_shadow_done: assert property (wr_ok && paddr == ADDR_CTRL && pwdata[0] &&
        cur_state == ST_ILL_BUSY |=> cur_state == ST_ILL_READY)
        else $error("shadow not ready on completion");
    chk_blank_shadow: assert property (cmd_wr && setup_code &&
        cur_state == ST_BLANK_BUSY |=> cur_state == ST_ILL_BLANK)
        else $error("setup in blank check not shadowed");
    chk_susp_shadow: assert property (cmd_wr && setup_code &&
        cur_state inside {ST_PROG_SUSP, ST_BP_SUSP_ES} |=> cur_state == ST_ILL_SUSP)
        else $error("setup in suspend not shadowed");
    chk_load1_branch: assert property (cmd_wr && cur_state == ST_BP_LOAD1_ES |=>
        cur_state == (cnt == 0 ? ST_BP_CONFIRM_ES : ST_BP_LOAD2_ES))
        else $error("first load branch wrong");
    chk_load2_count: assert property (cmd_wr && cur_state == ST_BP_LOAD2_ES |=>
        cur_state == (cnt == 0 ? ST_BP_CONFIRM_ES : ST_BP_LOAD2_ES))
        else $error("data load count wrong");
    chk_fact_data: assert property (cmd_wr && cur_state == ST_FACT_BUSY &&
        pwdata[15:0] != FACT_EXIT_DATA |=> fact_active)
        else $error("factory data taken as command");
    chk_fact_flag: assert property (fact_active == (cur_state == ST_FACT_BUSY))
        else $error("factory flag disagrees with state");
    chk_state_hold: assert property (!wr_ok |=> $stable(cur_state))
        else $error("state moved without a write");
    cov_ill_busy: cover property (cur_state == ST_ILL_BUSY);
    cov_seq_fail: cover property (seq_fail);
    cov_fact: cover property (fact_active);
endmodule : flcsm_core_asserts

bind flcsm_core flcsm_core_asserts #(.CNT_W(CNT_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cur_state(cur_state), .read_mode(read_mode), .seq_fail(seq_fail), .fact_active(fact_active)
);

// *** flcsm_decode.sv ***
`timescale 1ns/1ps
// ==========================================
// command code classifier
module flcsm_decode (
    input wire logic [7:0] code,
    output logic is_setup,
    output logic is_lockcfm,
    output logic is_cfgcfm,
    output logic is_status_sel,
    output logic is_illegal
);
    import flcsm_pkg::*;
    always_comb begin
        is_setup = (code == CODE_LOCK_SETUP) || (code == CODE_OTP_SETUP);
        is_lockcfm = (code == CODE_LOCK_CONFIRM) || (code == CODE_LOCKDOWN_CONFIRM);
        is_cfgcfm = (code == CODE_CFG_CONFIRM);
        is_status_sel = is_setup || (code == CODE_BLANK_SETUP) || (code == CODE_BLANK_CONFIRM);
        is_illegal = 1'b1;
        case (code)
            CODE_LOCK_SETUP, CODE_OTP_SETUP, CODE_LOCK_CONFIRM, CODE_LOCKDOWN_CONFIRM,
            CODE_CFG_CONFIRM, CODE_BLANK_SETUP, CODE_BLANK_CONFIRM, CODE_READ_ARRAY,
            CODE_PROG_SETUP, CODE_PROG_SETUP_ALT, CODE_BUF_PROG, CODE_ERASE_SETUP,
            CODE_FACT_SETUP, CODE_CONFIRM, CODE_SUSPEND, CODE_READ_STATUS,
            CODE_CLR_STATUS, CODE_READ_SIG, CODE_READ_CFI: is_illegal = 1'b0;
            default: is_illegal = 1'b1;
        endcase
    end
endmodule : flcsm_decode

// *** flcsm_host.sv ***
`timescale 1ns/1ps
// ==========================================
// host side: apb master issuing command writes
module flcsm_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // ok stays low if no answer within the bound
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        ok = 1'b0;
        rd = 32'h0000_0000;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                ok = 1'b1;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show no stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : flcsm_host

// *** flcsm_pkg.sv ***
// Function
// - while controller active, both cycles of lock/config or one-time setup are ignored
// - setup codes in program/erase busy go to illegal shadow; completion makes illegal-ready
// - setup codes in blank-check busy go illegal; others stay; completion returns to ready
// - setup codes in suspend go to illegal-suspend shadow, except lock setup in erase suspend; other inputs but buffer program keep suspend
// - first load with count zero goes to confirm, else to data loading
// - data loading counts down each write; confirm at zero, else keep loading
// - buffer sequence fails at confirm if any block differs from first block
// - factory programming only with status bit zero clear; busy while first block addressed
// - in factory busy every value except exit is data, not a command
// - all-ones data to a foreign block exits factory programming
// - codes outside the command set are illegal; in ready, busy and suspend they keep the state and output mode
// - undefined state and input combinations keep the current state
// - output modes are per bank, shown when read bank matches command bank
// - bank keeps last output mode until new command; transitions ignore output mode
// - setup, load, confirm, factory busy: any input selects status; completion leaves output
// - lock setup in erase suspend: config confirm selects array, others select status
// - ready/busy/suspend: lock, one-time and blank setups and blank confirm select status; other confirms, exit, illegal unchanged; config confirm array
// - every bank starts in read-array output mode after power-up
package flcsm_pkg;
    // ==========================================
    // registers (byte addresses)
    localparam logic [11:0] ADDR_CMD = 12'h000;
    localparam logic [11:0] ADDR_STATE = 12'h004;
    localparam logic [11:0] ADDR_MODE = 12'h008;
    localparam logic [11:0] ADDR_CTRL = 12'h00C;
    // cmd word: [15:0] data, [23:16] block, [26:24] bank
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_BLOCK_LSB = 16;
    localparam int CMD_BANK_LSB = 24;
    // ctrl word: [0] op done (write pulse), [1] status bit zero, [6:4] read bank sel
    localparam int CTRL_DONE_BIT = 0;
    localparam int CTRL_SR0_BIT = 1;
    localparam int CTRL_RBANK_LSB = 4;
    localparam logic [1:0] RESET_CTRL = 2'h0;
    // ==========================================
    // command codes
    localparam logic [7:0] CODE_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CODE_OTP_SETUP = 8'hC0;
    localparam logic [7:0] CODE_LOCK_CONFIRM = 8'h01;
    localparam logic [7:0] CODE_LOCKDOWN_CONFIRM = 8'h2F;
    localparam logic [7:0] CODE_CFG_CONFIRM = 8'h03;
    localparam logic [7:0] CODE_BLANK_SETUP = 8'hBC;
    localparam logic [7:0] CODE_BLANK_CONFIRM = 8'hCB;
    localparam logic [7:0] CODE_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CODE_PROG_SETUP = 8'h40;
    localparam logic [7:0] CODE_PROG_SETUP_ALT = 8'h10;
    localparam logic [7:0] CODE_BUF_PROG = 8'hE8;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CODE_FACT_SETUP = 8'h80;
    localparam logic [7:0] CODE_CONFIRM = 8'hD0;
    localparam logic [7:0] CODE_SUSPEND = 8'hB0;
    localparam logic [7:0] CODE_READ_STATUS = 8'h70;
    localparam logic [7:0] CODE_CLR_STATUS = 8'h50;
    localparam logic [7:0] CODE_READ_SIG = 8'h90;
    localparam logic [7:0] CODE_READ_CFI = 8'h98;
    localparam logic [15:0] FACT_EXIT_DATA = 16'hFFFF;
    // ==========================================
    typedef enum logic [1:0] {
        OUT_ARRAY = 2'h0,
        OUT_STATUS = 2'h1,
        OUT_SIG = 2'h2,
        OUT_CFI = 2'h3
    } flcsm_out_type;

    // gray along buffer setup -> load1 -> load2 -> confirm -> busy path
    typedef enum logic [4:0] {
        ST_READY = 5'h00,
        ST_LOCK_SETUP = 5'h01,
        ST_OTP_SETUP = 5'h03,
        ST_OTP_BUSY = 5'h02,
        ST_PROG_BUSY = 5'h06,
        ST_ERASE_BUSY = 5'h07,
        ST_BLANK_BUSY = 5'h05,
        ST_ERASE_SUSP = 5'h04,
        ST_PROG_SUSP = 5'h0C,
        ST_BP_SETUP_ES = 5'h0D,
        ST_BP_LOAD1_ES = 5'h0F,
        ST_BP_LOAD2_ES = 5'h0E,
        ST_BP_CONFIRM_ES = 5'h0A,
        ST_BP_BUSY_ES = 5'h0B,
        ST_BP_SUSP_ES = 5'h09,
        ST_LOCK_SETUP_ES = 5'h08,
        ST_FACT_SETUP = 5'h18,
        ST_FACT_BUSY = 5'h19,
        ST_ILL_BUSY = 5'h1B,
        ST_ILL_READY = 5'h1A,
        ST_ILL_BLANK = 5'h1E,
        ST_ILL_SUSP = 5'h1F,
        ST_ILL_BP_BUSY_ES = 5'h1D,
        ST_ERROR_READY = 5'h1C,
        ST_PROG_SETUP = 5'h16,
        ST_ERASE_SETUP = 5'h17,
        ST_BLANK_SETUP = 5'h15
    } flcsm_state_type;

    typedef struct packed {
        logic [2:0] bank;
        logic [7:0] block;
        logic [15:0] data;
    } flcsm_cmd_type;
endpackage : flcsm_pkg

// *** test_flash_lock_command_state_machine.sv ***
`timescale 1ns/1ps
// ==========================================
// scenario bench
module test_flash_lock_command_state_machine;
    import flcsm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, seq_fail, fact_active, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    flcsm_state_type cur_state;
    flcsm_out_type read_mode;
    int fails = 0;
    int total_checks = 0;
    always #20 pclk = ~pclk;
    flcsm_core dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cur_state(cur_state), .read_mode(read_mode), .seq_fail(seq_fail), .fact_active(fact_active));
    flcsm_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic ok;
        u_host.xfer(wr, a, d, rd, err, ok);
        if (ok !== 1'b1) begin
            fails++;
            tally_and_finish();
        end
    endtask : bus
    task automatic rst;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask : rst
    task automatic cmd(input logic [2:0] bank, input logic [7:0] blk, input logic [15:0] d);
        bus(1'b1, ADDR_CMD, {5'h00, bank, blk, d});
    endtask : cmd
    // nonzero bytes, high first, all to one bank and block
    task automatic go(input logic [31:0] s);
        for (int i = 3; i >= 0; i--) begin
            if (s[i*8 +: 8] != 8'h00) begin
                cmd(3'h2, 8'h05, {8'h00, s[i*8 +: 8]});
            end
        end
    endtask : go
    task automatic ctrl(input logic [2:0] rb, input logic sr0, input logic dn);
        bus(1'b1, ADDR_CTRL, {25'h000_0000, rb, 2'b00, sr0, dn});
    endtask : ctrl
    task automatic st(input flcsm_state_type e);
        @(negedge pclk);
        check(32'(cur_state), 32'(e));
    endtask : st
    task automatic md(input logic [2:0] rb, input logic [2:0] e);
        ctrl(rb, 1'b0, 1'b0);
        bus(1'b0, ADDR_MODE, 32'h0000_0000);
        check({29'h0, rd[2:0]}, {29'h0, e});
        @(negedge pclk);
        check({30'h0, read_mode}, {30'h0, e[1:0]});
    endtask : md
    // ==========================================
    // scenarios
    task automatic t_defaults;
        bus(1'b0, ADDR_MODE, 32'h0000_0000);
        check({30'h0, rd[1:0]}, {30'h0, OUT_ARRAY});
        bus(1'b0, ADDR_STATE, 32'h0000_0000);
        check({26'h0, rd[5:0]}, 32'h0000_0000);
        bus(1'b0, 12'h010, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
    endtask : t_defaults
    task automatic t_busy;
        rst();
        go(32'h0000_0040);
        cmd(3'h2, 8'h05, 16'h1234);
        st(ST_PROG_BUSY);
        go(32'h0000_00AA);
        st(ST_PROG_BUSY);
        go(32'h0000_0001);
        st(ST_PROG_BUSY);
        go(32'h0000_0060);
        st(ST_ILL_BUSY);
        ctrl(3'h0, 1'b0, 1'b1);
        st(ST_ILL_READY);
        go(32'h4011_B0C0);
        st(ST_ILL_SUSP);
    endtask : t_busy
    task automatic t_blank;
        rst();
        go(32'h00BC_CB01);
        st(ST_BLANK_BUSY);
        ctrl(3'h0, 1'b0, 1'b1);
        st(ST_READY);
        rst();
        go(32'h00BC_CBC0);
        st(ST_ILL_BLANK);
    endtask : t_blank
    task automatic t_susp;
        rst();
        go(32'h0020_D0B0);
        go(32'h0000_0001);
        st(ST_ERASE_SUSP);
        go(32'h0000_00C0);
        st(ST_ILL_SUSP);
        rst();
        go(32'h20D0_B060);
        md(3'h2, {1'b1, OUT_STATUS});
        go(32'h0000_0003);
        st(ST_ERASE_SUSP);
        md(3'h2, {1'b1, OUT_ARRAY});
    endtask : t_susp
    task automatic t_buffer;
        rst();
        go(32'h20D0_B0E8);
        cmd(3'h2, 8'h05, 16'h0000);
        st(ST_BP_LOAD1_ES);
        cmd(3'h2, 8'h05, 16'hABCD);
        st(ST_BP_CONFIRM_ES);
        go(32'h0000_00D0);
        st(ST_BP_BUSY_ES);
        go(32'h0000_0060);
        st(ST_ILL_BP_BUSY_ES);
        rst();
        go(32'h20D0_B0E8);
        cmd(3'h2, 8'h05, 16'h0001);
        cmd(3'h2, 8'h05, 16'h1111);
        st(ST_BP_LOAD2_ES);
        cmd(3'h2, 8'h06, 16'h2222);
        st(ST_BP_CONFIRM_ES);
        go(32'h0000_00D0);
        st(ST_ERASE_SUSP);
        check({31'h0, seq_fail}, 32'h0000_0001);
    endtask : t_buffer
    task automatic t_fact;
        rst();
        ctrl(3'h0, 1'b1, 1'b0);
        go(32'h0000_80D0);
        bus(1'b0, ADDR_STATE, 32'h0000_0000);
        check({31'h0, rd[4:0] == 5'(ST_FACT_BUSY)}, 32'h0000_0000);
        rst();
        go(32'h0000_80D0);
        st(ST_FACT_BUSY);
        go(32'h0000_0060);
        cmd(3'h2, 8'h05, FACT_EXIT_DATA);
        st(ST_FACT_BUSY);
        cmd(3'h2, 8'h06, FACT_EXIT_DATA);
        st(ST_READY);
    endtask : t_fact
    task automatic t_modes;
        rst();
        go(32'h0000_0090);
        md(3'h2, {1'b1, OUT_SIG});
        go(32'h0000_0001);
        md(3'h2, {1'b1, OUT_SIG});
        md(3'h5, {1'b0, OUT_ARRAY});
        go(32'h0000_0003);
        md(3'h2, {1'b1, OUT_ARRAY});
        go(32'h0000_00BC);
        go(32'h0000_0003);
        md(3'h2, {1'b1, OUT_STATUS});
    endtask : t_modes
    initial begin
        rst();
        t_defaults();
        t_busy();
        t_blank();
        t_susp();
        t_buffer();
        t_fact();
        t_modes();
        tally_and_finish();
    end
endmodule : test_flash_lock_command_state_machine
